//--- mid_pkg.sv
// Constants for the move instruction decoder
package mid_pkg;
    // ----------------------------------------------------------------
    // Instruction word layout
    // ----------------------------------------------------------------
    localparam int FMT_BIT      = 15;
    localparam int SRC_LSB      = 0;
    localparam int DST_MOD_LSB  = 8;
    localparam int DST_SUB_LSB  = 12;
    // ----------------------------------------------------------------
    // Module groups and the decoder's own register module
    // ----------------------------------------------------------------
    localparam logic [3:0] LAST_PERIPH_MOD = 4'h5;
    localparam logic [3:0] CORE_MOD        = 4'hb;
    // Core register indices (bits 4:3 of a destination need a prefix)
    localparam logic [4:0] IX_PFX0   = 5'h00; // 00..03 prefix slots
    localparam logic [4:0] IX_ACC    = 5'h04;
    localparam logic [4:0] IX_STACK  = 5'h05; // write push, read pop
    localparam logic [4:0] IX_IP     = 5'h06; // write jumps
    localparam logic [4:0] IX_ADD    = 5'h07; // write adds to acc
    localparam logic [4:0] IX_DPA    = 5'h08;
    localparam logic [4:0] IX_DPB    = 5'h09;
    localparam logic [4:0] IX_BASE   = 5'h0a;
    localparam logic [4:0] IX_OFFS   = 5'h0b;
    localparam logic [4:0] IX_AT_DPA = 5'h0c; // @dpa, step +1
    localparam logic [4:0] IX_AT_DPB = 5'h0d; // @dpb, step -1
    localparam logic [4:0] IX_AT_FP  = 5'h0e; // @fp, offset step +1
    localparam logic [4:0] IX_XOR    = 5'h0f; // write xors into acc
    // ----------------------------------------------------------------
    // Reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [15:0] IP_RESET    = 16'h8000;
    localparam int          STACK_DEPTH = 8;
    localparam int          STACK_AW    = 3;
endpackage

//--- mid_decoder.sv
// Single-cycle move instruction decoder with pointers and stack
// Contract
// - Instruction is one 16-bit word
// - Bit 15 selects source format
// - Format 0: source is 8-bit literal
// - Format 1: source is a register
// - Source module low nibble, index high nibble
// - Bits 8-14: destination module and sub-index
// - Sixteen sources, eight destinations without prefix
// - Upper destinations need a prefix write first
// - Fetch, decode, execute in one cycle
// - Certain register accesses trigger side effects
// - Side effects only on unused locations
// - Two independent 16-bit data pointers
// - Frame pointer is base plus offset
// - Read post-steps, write pre-steps the pointer
// - Frame pointer steps only the offset
// - Separate 16-bit stack, eight deep
// - Any register with accumulator; any-to-any moves
// - Sixteen modules of 32 registers each
// - Narrow-to-wide move fills upper from prefix
// - Undefined destination stores nothing, source effects stay
// - Modules 0-5 peripheral, 6-F system
`timescale 1ns/1ps
module mid_decoder
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // Program memory
    output logic [15:0]      pmem_addr_o,
    input  wire logic [15:0] instr_i,
    // External register modules, source side
    output logic [3:0]       reg_src_mod_o,
    output logic [4:0]       reg_src_idx_o,
    output logic             reg_rd_o,
    output logic             reg_src_periph_o,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_src_wide_i,
    input  wire logic        reg_src_def_i,
    // External register modules, destination side
    output logic [3:0]       reg_dst_mod_o,
    output logic [4:0]       reg_dst_idx_o,
    output logic             reg_wr_o,
    output logic [15:0]      reg_wdata_o,
    input  wire logic        reg_dst_wide_i,
    input  wire logic        reg_dst_def_i,
    // Data memory
    output logic [15:0]      dmem_raddr_o,
    output logic             dmem_rd_o,
    input  wire logic [15:0] dmem_rdata_i,
    output logic [15:0]      dmem_waddr_o,
    output logic             dmem_wr_o,
    output logic [15:0]      dmem_wdata_o,
    // Accumulator view
    output logic [15:0]      acc_o
);
    import mid_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] ip_r;
    logic [15:0] acc_r;
    logic [7:0]  prefix_register_r;
    logic [1:0]  pfx_dst_r;
    logic [15:0] data_pointer_a_r;
    logic [15:0] data_pointer_b_r;
    logic [15:0] frame_base_register_r;
    logic [7:0]  frame_offset_r;
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [STACK_AW-1:0] sp_r;

    // ----------------------------------------------------------------
    // Field split
    // ----------------------------------------------------------------
    logic       fmt;
    logic [7:0] src_fld;
    logic [3:0] dst_mod;
    logic [2:0] dst_sub;
    logic [4:0] dst_idx;
    logic [4:0] src_idx;
    logic       src_core;
    logic       dst_core;

    // One word, bit 15 picks the source view
    assign fmt      = instr_i[FMT_BIT];
    assign src_fld  = instr_i[SRC_LSB +: 8];
    assign dst_mod  = instr_i[DST_MOD_LSB +: 4];
    assign dst_sub  = instr_i[DST_SUB_LSB +: 3];
    // Upper destination bits come only from a prior prefix
    assign dst_idx  = {pfx_dst_r, dst_sub};
    // Module in low nibble, index in high nibble
    assign src_idx  = {1'b0, src_fld[7:4]};
    assign src_core = fmt && (src_fld[3:0] == CORE_MOD);
    assign dst_core = (dst_mod == CORE_MOD);

    // ----------------------------------------------------------------
    // Source value
    // ----------------------------------------------------------------
    logic [15:0] core_rval;
    logic [15:0] src_val;
    logic        src_wide;
    logic [15:0] wval;

    // Core register read mux, pointer windows read data memory
    always_comb
    begin
        case (src_idx)
            IX_ACC:    core_rval = acc_r;
            IX_STACK:  core_rval = stack_mem[sp_r - 3'd1];
            IX_IP:     core_rval = ip_r;
            IX_DPA:    core_rval = data_pointer_a_r;
            IX_DPB:    core_rval = data_pointer_b_r;
            IX_BASE:   core_rval = frame_base_register_r;
            IX_OFFS:   core_rval = {8'h00, frame_offset_r};
            IX_AT_DPA, IX_AT_DPB, IX_AT_FP: core_rval = dmem_rdata_i;
            default:   core_rval = {prefix_register_r, 8'h00};
        endcase
    end

    // Literal, core or external source; undefined reads prefix:00
    assign src_val  = !fmt           ? {8'h00, src_fld}
                    : src_core       ? core_rval
                    : !reg_src_def_i ? {prefix_register_r, 8'h00}
                    : reg_rdata_i;
    assign src_wide = fmt && (src_core || !reg_src_def_i || reg_src_wide_i);

    // Narrow source into wide target takes prefix as upper byte
    assign wval = src_wide ? src_val : {prefix_register_r, src_val[7:0]};

    // ----------------------------------------------------------------
    // External register ports
    // ----------------------------------------------------------------
    // Both module groups share one access path
    assign reg_src_mod_o    = src_fld[3:0];
    assign reg_src_idx_o    = src_idx;
    assign reg_rd_o         = fmt && !src_core;
    assign reg_src_periph_o = fmt && (src_fld[3:0] <= LAST_PERIPH_MOD);
    assign reg_dst_mod_o    = dst_mod;
    assign reg_dst_idx_o    = dst_idx;
    // Undefined destination stores nothing
    assign reg_wr_o    = !dst_core && reg_dst_def_i;
    assign reg_wdata_o = reg_dst_wide_i ? wval : {8'h00, wval[7:0]};
    assign acc_o       = acc_r;
    assign pmem_addr_o = ip_r;

    // ----------------------------------------------------------------
    // Pointer accesses: read post-step, write pre-step
    // ----------------------------------------------------------------
    logic rd_a, rd_b, rd_f, wr_a, wr_b, wr_f, stk_pop, stk_push;
    logic [15:0] dpa_mid, dpb_mid;
    logic [7:0]  offs_mid;

    assign rd_a = src_core && (src_idx == IX_AT_DPA);
    assign rd_b = src_core && (src_idx == IX_AT_DPB);
    assign rd_f = src_core && (src_idx == IX_AT_FP);
    assign wr_a = dst_core && (dst_idx == IX_AT_DPA);
    assign wr_b = dst_core && (dst_idx == IX_AT_DPB);
    assign wr_f = dst_core && (dst_idx == IX_AT_FP);

    // Value after the read step feeds the write's pre-step
    assign dpa_mid  = rd_a ? data_pointer_a_r + 16'h0001
                           : data_pointer_a_r;
    assign dpb_mid  = rd_b ? data_pointer_b_r - 16'h0001
                           : data_pointer_b_r;
    assign offs_mid = rd_f ? frame_offset_r + 8'h01 : frame_offset_r;

    // Read address is the pointer before stepping
    assign dmem_raddr_o = rd_a ? data_pointer_a_r
                        : rd_b ? data_pointer_b_r
                        : frame_base_register_r + {8'h00, frame_offset_r};
    assign dmem_rd_o = rd_a || rd_b || rd_f;

    // Write address is the pointer after stepping
    assign dmem_waddr_o = wr_a ? dpa_mid + 16'h0001
                        : wr_b ? dpb_mid - 16'h0001
                        : frame_base_register_r + {8'h00, offs_mid + 8'h01};
    assign dmem_wr_o    = wr_a || wr_b || wr_f;
    assign dmem_wdata_o = wval;

    // ----------------------------------------------------------------
    // Sequential state, one instruction per clock
    // ----------------------------------------------------------------
    // Instruction pointer; a write jumps on the next fetch
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            ip_r <= IP_RESET;
        else if (dst_core && dst_idx == IX_IP)
            ip_r <= wval;
        else
            ip_r <= ip_r + 16'h0001;
    end

    // Prefix holds for exactly the next instruction
    always_ff @(posedge core_clk_i)
    begin
        if (resetn_i && dst_core && dst_idx[4:2] == IX_PFX0[4:2])
            {prefix_register_r, pfx_dst_r} <= {wval[7:0], dst_idx[1:0]};
        else
            {prefix_register_r, pfx_dst_r} <= 10'h000;
    end

    // Accumulator: plain load, or operate with any source
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            acc_r <= 16'h0000;
        else if (dst_core && dst_idx == IX_ACC)
            acc_r <= wval;
        else if (dst_core && dst_idx == IX_ADD)
            acc_r <= acc_r + wval;
        else if (dst_core && dst_idx == IX_XOR)
            acc_r <= acc_r ^ wval;
    end

    // Two independent pointers; loads override stepping
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            {data_pointer_a_r, data_pointer_b_r} <= 32'h0000_0000;
        else
        begin
            if (dst_core && dst_idx == IX_DPA)
                data_pointer_a_r <= wval;
            else
                data_pointer_a_r <= wr_a ? dpa_mid + 16'h0001
                                         : dpa_mid;
            if (dst_core && dst_idx == IX_DPB)
                data_pointer_b_r <= wval;
            else
                data_pointer_b_r <= wr_b ? dpb_mid - 16'h0001
                                         : dpb_mid;
        end
    end

    // Frame stepping touches the offset only
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            {frame_base_register_r, frame_offset_r} <= 24'h00_0000;
        else
        begin
            if (dst_core && dst_idx == IX_BASE)
                frame_base_register_r <= wval;
            if (dst_core && dst_idx == IX_OFFS)
                frame_offset_r <= wval[7:0];
            else
                frame_offset_r <= wr_f ? offs_mid + 8'h01
                                       : offs_mid;
        end
    end

    // Dedicated stack; pop on read, push on write, wraps silently
    assign stk_pop  = src_core && (src_idx == IX_STACK);
    assign stk_push = dst_core && (dst_idx == IX_STACK);
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            sp_r <= '0;
        else if (stk_push && !stk_pop)
            sp_r <= sp_r + 3'd1;
        else if (stk_pop && !stk_push)
            sp_r <= sp_r - 3'd1;
        if (stk_push)
            stack_mem[stk_pop ? sp_r - 3'd1 : sp_r] <= wval;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_pfx_clear: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !(dst_core && dst_idx[4:2] == 3'b000)
        |=> prefix_register_r == 8'h00 && pfx_dst_r == 2'b00)
        else $error("prefix not cleared after one cycle");

    chk_imm_upper: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !fmt |-> wval == {prefix_register_r, instr_i[7:0]})
        else $error("literal move value wrong");

    chk_src_fields: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        reg_rd_o |-> reg_src_mod_o == instr_i[3:0]
                  && reg_src_idx_o == {1'b0, instr_i[7:4]})
        else $error("source fields wrong");

    chk_dst_fields: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        reg_wr_o |-> reg_dst_mod_o == instr_i[11:8]
                  && reg_dst_idx_o[2:0] == instr_i[14:12]
                  && reg_dst_idx_o[4:3] == pfx_dst_r)
        else $error("destination fields wrong");

    chk_undef_dst: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !reg_dst_def_i |-> !reg_wr_o)
        else $error("write to undefined destination");

    chk_dpa_post: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        rd_a && !wr_a && !(dst_core && dst_idx == IX_DPA)
        |-> dmem_raddr_o == data_pointer_a_r
            ##1 data_pointer_a_r == $past(dmem_raddr_o) + 16'h0001)
        else $error("data pointer read not post-stepped");

    chk_dpb_pre: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        wr_b && !rd_b |-> dmem_waddr_o == data_pointer_b_r - 16'h0001
            ##1 data_pointer_b_r == $past(dmem_waddr_o))
        else $error("data pointer write not pre-stepped");

    chk_fp_base: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (rd_f || wr_f) && !(dst_core && dst_idx == IX_BASE)
        |=> $stable(frame_base_register_r))
        else $error("frame step moved the base");

    chk_ip_step: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !(dst_core && dst_idx == IX_IP)
        |=> ip_r == $past(ip_r) + 16'h0001)
        else $error("fetch address did not advance");

    chk_stack_lifo: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (dst_core && dst_idx == IX_STACK && !src_core)
        ##1 (src_core && src_idx == IX_STACK && !dst_core)
        |-> core_rval == $past(wval))
        else $error("stack pop differs from push");
endmodule

//--- mid_far_model.sv
// Far-side model: program memory, register modules and data memory
`timescale 1ns/1ps
module mid_far_model
(
    // Clock
    input  wire logic        core_clk_i,
    // Program memory
    input  wire logic [15:0] pmem_addr_i,
    output logic [15:0]      instr_o,
    // Register modules
    input  wire logic [3:0]  src_mod_i,
    input  wire logic [4:0]  src_idx_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    output logic             src_wide_o,
    output logic             src_def_o,
    input  wire logic [3:0]  dst_mod_i,
    input  wire logic [4:0]  dst_idx_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    output logic             dst_wide_o,
    output logic             dst_def_o,
    // Data memory
    input  wire logic [15:0] dm_raddr_i,
    input  wire logic        dm_rd_i,
    output logic [15:0]      dm_rdata_o,
    input  wire logic [15:0] dm_waddr_i,
    input  wire logic        dm_wr_i,
    input  wire logic [15:0] dm_wdata_i
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [15:0] pm [0:255];
    logic [15:0] regs [0:15][0:31];
    logic [15:0] dm [0:255];
    logic [15:0] last_rd_r;
    logic [15:0] last_dm_r;

    // Known start contents so reads give predictable words
    initial
    begin
        last_rd_r = 16'h0000;
        last_dm_r = 16'h0000;
        for (int m = 0; m < 16; m++)
            for (int i = 0; i < 32; i++)
                regs[m][i] = 16'h0000;
        for (int i = 0; i < 256; i++)
            dm[i] = {i[7:0], ~i[7:0]};
    end

    // ----------------------------------------------------------------
    // Combinational answers
    // ----------------------------------------------------------------
    // Memory answers in the same cycle; address wraps over 256 words
    assign instr_o = pm[pmem_addr_i[7:0]];
    // Modules 0..5 hold byte registers, 6..F word registers
    assign src_wide_o = (src_mod_i > 4'h5);
    assign dst_wide_o = (dst_mod_i > 4'h5);
    // Indices 7, 15, 23 and 31 of each module left empty for dummy moves
    assign src_def_o = (src_idx_i[2:0] != 3'h7);
    assign dst_def_o = (dst_idx_i[2:0] != 3'h7);
    // Released buses show the inverse, so stale data never passes
    assign rdata_o    = rd_i ? regs[src_mod_i][src_idx_i] : ~last_rd_r;
    assign dm_rdata_o = dm_rd_i ? dm[dm_raddr_i[7:0]] : ~last_dm_r;

    // Writes land at the clock edge; undefined places keep nothing
    always @(posedge core_clk_i)
    begin
        if (rd_i)
            last_rd_r <= rdata_o;
        if (dm_rd_i)
            last_dm_r <= dm_rdata_o;
        if (wr_i && dst_def_o)
            regs[dst_mod_i][dst_idx_i] <= dst_wide_o ? wdata_i
                                        : {8'h00, wdata_i[7:0]};
        if (dm_wr_i)
            dm[dm_waddr_i[7:0]] <= dm_wdata_i;
    end
endmodule

//--- mid_decoder_tb.sv
// Self-checking testbench for the move instruction decoder
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module mid_decoder_tb;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    int          n_fail   = 0;
    int          n_tests  = 0;
    int          cyc      = 0;
    logic [15:0] pmem_addr, instr, rdata, wdata, acc;
    logic [15:0] dm_raddr, dm_rdata, dm_waddr, dm_wdata;
    logic [3:0]  src_mod, dst_mod;
    logic [4:0]  src_idx, dst_idx;
    logic        rd, periph, src_wide, src_def, wr, dst_wide, dst_def;
    logic        dm_rd, dm_wr;

    mid_decoder u_mid_decoder (.core_clk_i(core_clk), .resetn_i(resetn),
        .pmem_addr_o(pmem_addr), .instr_i(instr),
        .reg_src_mod_o(src_mod), .reg_src_idx_o(src_idx), .reg_rd_o(rd),
        .reg_src_periph_o(periph), .reg_rdata_i(rdata),
        .reg_src_wide_i(src_wide), .reg_src_def_i(src_def),
        .reg_dst_mod_o(dst_mod), .reg_dst_idx_o(dst_idx), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_dst_wide_i(dst_wide),
        .reg_dst_def_i(dst_def), .dmem_raddr_o(dm_raddr),
        .dmem_rd_o(dm_rd), .dmem_rdata_i(dm_rdata),
        .dmem_waddr_o(dm_waddr), .dmem_wr_o(dm_wr),
        .dmem_wdata_o(dm_wdata), .acc_o(acc));

    mid_far_model u_far (.core_clk_i(core_clk), .pmem_addr_i(pmem_addr),
        .instr_o(instr), .src_mod_i(src_mod), .src_idx_i(src_idx),
        .rd_i(rd), .rdata_o(rdata), .src_wide_o(src_wide),
        .src_def_o(src_def), .dst_mod_i(dst_mod), .dst_idx_i(dst_idx),
        .wr_i(wr), .wdata_i(wdata), .dst_wide_o(dst_wide),
        .dst_def_o(dst_def), .dm_raddr_i(dm_raddr), .dm_rd_i(dm_rd),
        .dm_rdata_o(dm_rdata), .dm_waddr_i(dm_waddr), .dm_wr_i(dm_wr),
        .dm_wdata_i(dm_wdata));

    // 40 MHz core clock
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard: the whole run needs well under 200 cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Load a program at the reset address while reset is held
    task automatic load(input logic [15:0] w[$]);
        @(negedge core_clk);
        resetn = 1'b0;
        for (int i = 0; i < 256; i++)
            u_far.pm[i] = 16'h7300; // Dummy move, harmless filler
        foreach (w[i])
            u_far.pm[i] = w[i];
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        #1;
    endtask

    // One instruction executes at the rising edge inside this wait
    task automatic step;
        @(negedge core_clk);
        #1;
    endtask

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Literal versus register source on the same low byte
    task automatic t_format;
        u_far.regs[7][3] = 16'h1234;
        u_far.regs[3][2] = 16'h00a5;
        load({16'h4b37, 16'hcb37, 16'hcb23, 16'h2312});
        `CHK(pmem_addr, mid_pkg::IP_RESET)
        `CHK(rd, 1'b0)
        step();
        `CHK(acc, 16'h0037)
        `CHK(pmem_addr, mid_pkg::IP_RESET + 16'h0001)
        `CHK(rd, 1'b1)
        `CHK(src_mod, 4'h7)
        `CHK(src_idx, 5'h03)
        `CHK(periph, 1'b0)
        step();
        `CHK(acc, 16'h1234)
        `CHK(periph, 1'b1)
        step();
        `CHK(acc, 16'h00a5)
        `CHK(wr, 1'b1)
        `CHK(dst_mod, 4'h3)
        `CHK(dst_idx, 5'h02)
        `CHK(wdata, 16'h0012)
        $display("test format done");
    endtask

    // Prefix reaches an upper index and fills the high byte once
    task automatic t_prefix;
        load({16'h1b34, 16'h2756, 16'h2756});
        `CHK(wr, 1'b0)
        step();
        `CHK(dst_idx, 5'h0a)
        `CHK(wdata, 16'h3456)
        `CHK(wr, 1'b1)
        step();
        `CHK(dst_idx, 5'h02)
        `CHK(wdata, 16'h0056)
        $display("test prefix done");
    endtask

    // Move to an empty place still steps the source pointer
    task automatic t_dummy;
        load({16'hf3cb, 16'hcbcb, 16'h0b12, 16'hcb73});
        `CHK(wr, 1'b0)
        `CHK(dm_rd, 1'b1)
        `CHK(dm_raddr, 16'h0000)
        step();
        `CHK(dm_raddr, 16'h0001)
        `CHK(acc, 16'h0000)
        step();
        `CHK(acc, 16'h01fe)
        repeat (2) step();
        `CHK(acc, 16'h1200)
        $display("test dummy done");
    endtask

    // Pre-step on write, post-step on read, offset wraps alone
    task automatic t_pointers;
        load({16'h1b12, 16'h1b10, 16'h1b00, 16'h5b77, 16'hcbcb,
              16'h1bab, 16'h2b00, 16'h1b00, 16'h3bff, 16'hcbeb,
              16'hcbeb, 16'hcbab});
        repeat (3) step();
        `CHK(dm_wr, 1'b1)
        `CHK(dm_waddr, 16'h120f)
        `CHK(dm_wdata, 16'h0077)
        step();
        `CHK(dm_raddr, 16'h0000)
        repeat (5) step();
        `CHK(dm_raddr, 16'habff)
        step();
        `CHK(acc, 16'hff00)
        `CHK(dm_raddr, 16'hab00)
        repeat (2) step();
        `CHK(acc, 16'hab00)
        $display("test pointers done");
    endtask

    // Fill the stack to its depth, then empty it in reverse
    task automatic t_stack;
        logic [15:0] w[$];
        for (int i = 1; i <= 8; i++)
            w.push_back(16'h5b00 | (16'h0011 * i));
        repeat (8) w.push_back(16'hcb5b);
        load(w);
        repeat (8) step();
        for (int i = 8; i >= 1; i--)
        begin
            step();
            `CHK(acc, 16'h0011 * i)
        end
        $display("test stack done");
    endtask

    // Add, exclusive-or and jump triggered by writes
    task automatic t_effects;
        u_far.regs[7][3] = 16'h1234;
        load({16'h4b05, 16'h7b03, 16'h1b00, 16'h7b0f, 16'hfb37,
              16'h0b80, 16'h6b10});
        step();
        `CHK(wr, 1'b0)
        step();
        `CHK(acc, 16'h0008)
        repeat (2) step();
        `CHK(acc, 16'h0007)
        step();
        `CHK(acc, 16'h123b)
        repeat (2) step();
        `CHK(pmem_addr, 16'h8010)
        $display("test effects done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        t_format();
        t_prefix();
        t_dummy();
        t_pointers();
        t_stack();
        t_effects();
        summarize();
    end
endmodule
